// file: swk_pkg.sv
// Constants, state codes and carrier types of the stop-mode wake sequencer.
package swk_pkg;

   // ******************************************************************
   // Register map (byte addresses on the APB)
   // ******************************************************************
   localparam logic [7:0] SWK_ADDR_CTRL     = 8'h00;
   localparam logic [7:0] SWK_ADDR_WAKE_EN  = 8'h04;
   localparam logic [7:0] SWK_ADDR_T3       = 8'h08;
   localparam logic [7:0] SWK_ADDR_T4       = 8'h0C;
   localparam logic [7:0] SWK_ADDR_STATUS   = 8'h10;
   localparam logic [7:0] SWK_ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] SWK_ADDR_IRQ_MASK = 8'h18;
   localparam logic [7:0] SWK_ADDR_PULLUP   = 8'h1C;

   // ******************************************************************
   // Field positions
   // ******************************************************************
   localparam int SWK_CTRL_HALT   = 0;
   localparam int SWK_CTRL_SUBSEL = 1;
   localparam int SWK_CTRL_RUN    = 2;

   localparam int SWK_IRQ_WAKE    = 0;
   localparam int SWK_IRQ_T3      = 1;
   localparam int SWK_IRQ_T4      = 2;
   localparam int SWK_IRQ_RESUME  = 3;
   localparam int SWK_NUM_IRQ     = 4;

   // Wake source index doubles as the interrupt vector number.
   localparam int SWK_SRC_IRQ0    = 0;
   localparam int SWK_SRC_IRQ1    = 1;
   localparam int SWK_SRC_CNTR    = 2;
   localparam int SWK_SRC_TIMER1  = 3;
   localparam int SWK_SRC_TIMER2  = 4;
   localparam int SWK_SRC_SERIAL  = 5;
   localparam int SWK_SRC_KEY     = 6;
   localparam int SWK_NUM_SRC     = 7;

   // Synchronised pins: three wake pins and the sub oscillator clock.
   localparam int SWK_PIN_SUBCLK  = 3;
   localparam int SWK_NUM_PINS    = 4;
   localparam int SWK_KEY_BITS    = 8;

   // ******************************************************************
   // Reset values and counts
   // ******************************************************************
   localparam logic [7:0] SWK_T3_HALT_LOAD  = 8'hFF;
   localparam logic [7:0] SWK_T4_HALT_LOAD  = 8'h07;
   localparam logic [7:0] SWK_TIMER_RESET   = 8'hFF;
   localparam logic [3:0] SWK_PRESCALE_LAST = 4'hF;
   localparam logic [2:0] SWK_CTRL_RESET    = 3'h0;
   localparam logic [6:0] SWK_WAKE_EN_RESET = 7'h00;
   localparam logic [3:0] SWK_MASK_RESET    = 4'h0;
   localparam logic [7:0] SWK_PULLUP_RESET  = 8'h00;

   typedef enum logic [1:0] {
      SWK_RUN       = 2'b00,
      SWK_HALTED    = 2'b01,
      SWK_STABILISE = 2'b11,
      SWK_RESUME    = 2'b10
   } swk_state_e;

   typedef struct packed {
      logic timer1;
      logic timer2;
      logic serial;
   } swk_wake_s;

   typedef struct packed {
      logic main_osc_enable;
      logic sub_osc_enable;
      logic internal_clock;
      logic cpu_stopped;
   } swk_clk_s;

endpackage

// file: swk_key_wake.sv
// Key port input conditioning with per-bit pull-up and key wake-up detect.
`timescale 1ns/10ps
`default_nettype none
module swk_key_wake
   import swk_pkg::*;
(
   input  wire logic                    pclk,          // System clock.
   input  wire logic                    presetn,       // Async reset, low.
   input  wire logic [SWK_KEY_BITS-1:0] key_pins,      // Key port pins.
   input  wire logic [SWK_KEY_BITS-1:0] pullup_sel,    // Pull-up select.
   output logic      [SWK_KEY_BITS-1:0] key_pullup_en, // Pull-up drive.
   output logic      [SWK_KEY_BITS-1:0] key_level,     // Filtered level.
   output logic                         key_wake       // Key press pulse.
);
   import swk_pkg::*;

   typedef struct packed {
      logic [SWK_KEY_BITS-1:0] s1;
      logic [SWK_KEY_BITS-1:0] s2;
      logic [SWK_KEY_BITS-1:0] s3;
      logic [SWK_KEY_BITS-1:0] lvl;
      logic [SWK_KEY_BITS-1:0] pull;
      logic                    wake;
   } swk_key_s;

   swk_key_s r_q;
   swk_key_s r_d;

   always_comb
   begin
      r_d      = r_q;
      r_d.wake = 1'b0;
      r_d.s1   = key_pins;
      r_d.s2   = r_q.s1;
      r_d.s3   = r_q.s2;
      r_d.pull = pullup_sel;
      for (int i = 0; i < SWK_KEY_BITS; i++)
      begin
         if ((r_q.s2[i] == r_q.s3[i]) && (r_q.s3[i] != r_q.lvl[i]))
         begin
            r_d.lvl[i] = r_q.s3[i];
            // RULE10 key press wakes
            if (!r_q.s3[i])
            begin
               r_d.wake = 1'b1;
            end
         end
      end
   end

   // Levels reset high, as idle keys are pulled up.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_q <= '{s1: '1, s2: '1, s3: '1, lvl: '1,
                  pull: SWK_PULLUP_RESET, wake: 1'b0};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // RULE10 per-bit pull-up
   assign key_pullup_en = r_q.pull;
   assign key_level     = r_q.lvl;
   assign key_wake      = r_q.wake;

endmodule // swk_key_wake
`default_nettype wire

// file: swk_sequencer.sv
// Stop-mode entry and wake-up sequencer with APB registers and interrupt.
//
// Summary of operation
// RULE1 - Software disables the timer 3 and timer 4 interrupts before halting.
// RULE2 - Software selects a divide-by-16 source for timer 3 and runs both.
// RULE3 - Software loads timer values that cannot overflow before the halt.
// RULE4 - Software enables the wake source and clears the timer 4 flag first.
// RULE5 - The halt command stops both the main and the sub oscillator.
// RULE6 - Only pins, counters, timers 1 and 2, serial and keys end the halt.
// RULE7 - A wake restarts both oscillators and runs the timer 3 to 4 chain.
// RULE8 - The system clock restarts only when timer 4 overflows.
// RULE9 - Execution resumes at the vector of the source that woke the device.
// RULE10 - The key port can wake the device and has a pull-up on each bit.
// RULE11 - Halting chains the timers and loads them with FF and 07.
// RULE12 - The internal clock stays high until timer 4 overflows.
// RULE13 - All registers keep their contents while the device is halted.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module swk_sequencer
   import swk_pkg::*;
(
   input  wire logic                    pclk,                 // 50 MHz clock.
   input  wire logic                    presetn,              // Async, low.
   input  wire logic                    psel,                 // APB select.
   input  wire logic                    penable,              // APB enable.
   input  wire logic                    pwrite,               // APB write.
   input  wire logic [7:0]              paddr,                // APB address.
   input  wire logic [31:0]             pwdata,               // APB wdata.
   output logic      [31:0]             prdata,               // APB rdata.
   output logic                         pready,               // APB ready.
   output logic                         pslverr,              // APB error.
   input  wire logic                    external_irq_zero,    // Pin irq 0.
   input  wire logic                    external_irq_one,     // Pin irq 1.
   input  wire logic                    counter_pin_irq,      // Counter pin.
   input  wire logic                    sub_oscillator_clock, // Sub clock.
   input  wire swk_pkg::swk_wake_s      wake_src,             // Peer events.
   input  wire logic [SWK_KEY_BITS-1:0] key_pins,             // Key port.
   output logic      [SWK_KEY_BITS-1:0] key_pullup_en,        // Pull-ups.
   output swk_pkg::swk_clk_s            clk_ctl,              // Clock ctrl.
   output logic                         wake_resume,          // Resume pulse.
   output logic      [2:0]              wake_vector,          // Vector index.
   output logic                         irq                   // Interrupt.
);
   import swk_pkg::*;

   // ******************************************************************
   // State
   // ******************************************************************
   typedef struct packed {
      swk_state_e              state;
      logic [2:0]              ctrl;
      logic [SWK_NUM_SRC-1:0]  wake_en;
      logic [7:0]              t3;
      logic [7:0]              t4;
      logic [3:0]              pre_main;
      logic [3:0]              pre_sub;
      logic [SWK_NUM_PINS-1:0] s1;
      logic [SWK_NUM_PINS-1:0] s2;
      logic [SWK_NUM_PINS-1:0] s3;
      logic [SWK_NUM_PINS-1:0] lvl;
      logic [SWK_NUM_IRQ-1:0]  stat;
      logic [SWK_NUM_IRQ-1:0]  mask;
      logic [7:0]              pull_sel;
      logic [31:0]             rdata;
      logic [2:0]              vec;
      logic                    resume;
      logic                    main_en;
      logic                    sub_en;
      logic                    phi;
      logic                    irq;
   } swk_seq_s;

   swk_seq_s r_q;
   swk_seq_s r_d;

   logic [SWK_KEY_BITS-1:0] key_level;
   logic                    key_wake;

   // ******************************************************************
   // Decode helpers
   // ******************************************************************
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= SWK_ADDR_PULLUP);
   endfunction

   // Lowest index wins when several sources arrive together.
   function automatic logic [2:0] first_src(input logic [SWK_NUM_SRC-1:0] v);
      first_src = 3'h0;
      for (int i = SWK_NUM_SRC - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            first_src = 3'(i);
         end
      end
   endfunction

   // ******************************************************************
   // Key port
   // ******************************************************************
   swk_key_wake u_key (
      .pclk          (pclk),
      .presetn       (presetn),
      .key_pins      (key_pins),
      .pullup_sel    (r_q.pull_sel),
      .key_pullup_en (key_pullup_en),
      .key_level     (key_level),
      .key_wake      (key_wake)
   );

   // ******************************************************************
   // Next state
   // ******************************************************************
   logic [SWK_NUM_PINS-1:0] pin_in;
   logic [SWK_NUM_PINS-1:0] pin_edge;
   logic [SWK_NUM_SRC-1:0]  wake_ev;
   logic [SWK_NUM_IRQ-1:0]  irq_set;
   logic [SWK_NUM_IRQ-1:0]  irq_clr;
   logic                    wr;
   logic                    main_tick;
   logic                    sub_tick;
   logic                    tick;
   logic                    t_en;
   logic                    t3_uf;
   logic                    t4_uf;
   logic                    halt_cmd;

   assign pin_in = {sub_oscillator_clock, counter_pin_irq,
                    external_irq_one, external_irq_zero};

   always_comb
   begin
      r_d       = r_q;
      r_d.resume = 1'b0;
      pin_edge  = '0;
      irq_set   = '0;
      irq_clr   = '0;
      main_tick = 1'b0;
      sub_tick  = 1'b0;
      t3_uf     = 1'b0;
      t4_uf     = 1'b0;

      // A pin change counts once the second and third stages agree.
      r_d.s1 = pin_in;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      for (int i = 0; i < SWK_NUM_PINS; i++)
      begin
         if ((r_q.s2[i] == r_q.s3[i]) && (r_q.s3[i] != r_q.lvl[i]))
         begin
            r_d.lvl[i]  = r_q.s3[i];
            pin_edge[i] = 1'b1;
         end
      end

      // RULE6 timers 3 and 4 excluded
      wake_ev = {key_wake, wake_src.serial, wake_src.timer2,
                 wake_src.timer1, pin_edge[SWK_SRC_CNTR],
                 pin_edge[SWK_SRC_IRQ1], pin_edge[SWK_SRC_IRQ0]};

      // Divide-by-16 prescalers only run while their oscillator runs.
      if (r_q.main_en)
      begin
         r_d.pre_main = r_q.pre_main + 4'h1;
         main_tick    = (r_q.pre_main == SWK_PRESCALE_LAST);
      end
      if (r_q.sub_en && pin_edge[SWK_PIN_SUBCLK] && r_q.s3[SWK_PIN_SUBCLK])
      begin
         r_d.pre_sub = r_q.pre_sub + 4'h1;
         sub_tick    = (r_q.pre_sub == SWK_PRESCALE_LAST);
      end
      tick = r_q.ctrl[SWK_CTRL_SUBSEL] ? sub_tick : main_tick;

      // RULE7 divided clock feeds the chain
      t_en = ((r_q.state == SWK_RUN) && r_q.ctrl[SWK_CTRL_RUN]) ||
             (r_q.state == SWK_STABILISE);
      if (t_en && tick)
      begin
         r_d.t3 = r_q.t3 - 8'h01;
         t3_uf  = (r_q.t3 == 8'h00);
         if (t3_uf)
         begin
            r_d.t4 = r_q.t4 - 8'h01;
            t4_uf  = (r_q.t4 == 8'h00);
         end
      end
      irq_set[SWK_IRQ_T3] = t3_uf;
      irq_set[SWK_IRQ_T4] = t4_uf;

      // RULE13 writes blocked outside normal run
      wr = psel && penable && pwrite && addr_ok(paddr) &&
           (r_q.state == SWK_RUN);
      halt_cmd = 1'b0;
      if (wr)
      begin
         unique case (paddr)
            SWK_ADDR_CTRL:
            begin
               r_d.ctrl = pwdata[2:0];
               r_d.ctrl[SWK_CTRL_HALT] = 1'b0;
               halt_cmd = pwdata[SWK_CTRL_HALT];
            end
            SWK_ADDR_WAKE_EN:  r_d.wake_en = pwdata[SWK_NUM_SRC-1:0];
            SWK_ADDR_T3:       r_d.t3      = pwdata[7:0];
            SWK_ADDR_T4:       r_d.t4      = pwdata[7:0];
            SWK_ADDR_IRQ_STAT: irq_clr     = pwdata[SWK_NUM_IRQ-1:0];
            SWK_ADDR_IRQ_MASK: r_d.mask    = pwdata[SWK_NUM_IRQ-1:0];
            SWK_ADDR_PULLUP:   r_d.pull_sel = pwdata[7:0];
            default:           r_d.pull_sel = r_q.pull_sel;
         endcase
      end

      unique case (r_q.state)
         SWK_RUN:
         begin
            if (halt_cmd)
            begin
               // RULE5 both oscillators stop
               r_d.state   = SWK_HALTED;
               r_d.main_en = 1'b0;
               r_d.sub_en  = 1'b0;
               // RULE11 forced chain preload
               r_d.t3      = SWK_T3_HALT_LOAD;
               r_d.t4      = SWK_T4_HALT_LOAD;
            end
         end
         SWK_HALTED:
         begin
            // RULE6 accepted wake ends the halt
            if (|(wake_ev & r_q.wake_en))
            begin
               r_d.state   = SWK_STABILISE;
               r_d.vec     = first_src(wake_ev & r_q.wake_en);
               // RULE7 oscillators restart
               r_d.main_en = 1'b1;
               r_d.sub_en  = 1'b1;
               irq_set[SWK_IRQ_WAKE] = 1'b1;
            end
         end
         SWK_STABILISE:
         begin
            // RULE8 wait for timer 4 overflow
            if (t4_uf)
            begin
               r_d.state = SWK_RESUME;
            end
         end
         SWK_RESUME:
         begin
            // RULE9 resume at wake vector
            r_d.state  = SWK_RUN;
            r_d.resume = 1'b1;
            irq_set[SWK_IRQ_RESUME] = 1'b1;
         end
      endcase

      // RULE12 clock held high unless running
      r_d.phi = ((r_q.state == SWK_RUN) && (r_d.state == SWK_RUN)) ?
                ~r_q.phi : 1'b1;

      // A flag raised in the clearing cycle survives the clear.
      r_d.stat = (r_q.stat & ~irq_clr) | irq_set;
      r_d.irq  = |(r_d.stat & r_q.mask);

      // Read data is captured in the setup phase, so no wait state.
      if (psel && !penable)
      begin
         unique case (paddr)
            SWK_ADDR_CTRL:     r_d.rdata = {29'h0, r_q.ctrl};
            SWK_ADDR_WAKE_EN:  r_d.rdata = {25'h0, r_q.wake_en};
            SWK_ADDR_T3:       r_d.rdata = {24'h0, r_q.t3};
            SWK_ADDR_T4:       r_d.rdata = {24'h0, r_q.t4};
            SWK_ADDR_STATUS:   r_d.rdata = {16'h0, key_level, 1'b0, r_q.vec,
                                            r_q.sub_en, r_q.main_en,
                                            r_q.state};
            SWK_ADDR_IRQ_STAT: r_d.rdata = {28'h0, r_q.stat};
            SWK_ADDR_IRQ_MASK: r_d.rdata = {28'h0, r_q.mask};
            SWK_ADDR_PULLUP:   r_d.rdata = {24'h0, r_q.pull_sel};
            default:           r_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ******************************************************************
   // Registers
   // ******************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_q <= '{state: SWK_RUN, ctrl: SWK_CTRL_RESET,
                  wake_en: SWK_WAKE_EN_RESET, t3: SWK_TIMER_RESET,
                  t4: SWK_TIMER_RESET, pre_main: 4'h0, pre_sub: 4'h0,
                  s1: '0, s2: '0, s3: '0, lvl: '0, stat: '0,
                  mask: SWK_MASK_RESET, pull_sel: SWK_PULLUP_RESET,
                  rdata: 32'h0000_0000, vec: 3'h0, resume: 1'b0,
                  main_en: 1'b1, sub_en: 1'b1, phi: 1'b1, irq: 1'b0};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************
   assign prdata  = r_q.rdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);

   assign clk_ctl.main_osc_enable = r_q.main_en;
   assign clk_ctl.sub_osc_enable  = r_q.sub_en;
   assign clk_ctl.internal_clock  = r_q.phi;
   assign clk_ctl.cpu_stopped     = (r_q.state != SWK_RUN);
   assign wake_resume = r_q.resume;
   assign wake_vector = r_q.vec;
   assign irq         = r_q.irq;

endmodule // swk_sequencer
`default_nettype wire

// file: swk_sequencer_checker.sv
// Port-level assertions for the stop-mode wake sequencer.
`timescale 1ns/10ps
`default_nettype none
module swk_sequencer_checker
   import swk_pkg::*;
(
   input wire logic                     pclk,          // Clock.
   input wire logic                     presetn,       // Reset, low.
   input wire logic                     psel,          // APB select.
   input wire logic                     penable,       // APB enable.
   input wire logic                     pwrite,        // APB write.
   input wire logic [7:0]               paddr,         // APB address.
   input wire logic [31:0]              pwdata,        // APB wdata.
   input wire logic                     pslverr,       // APB error.
   input wire logic [SWK_KEY_BITS-1:0]  key_pullup_en, // Pull-ups.
   input wire swk_pkg::swk_clk_s        clk_ctl,       // Clock ctrl.
   input wire logic                     wake_resume,   // Resume pulse.
   input wire logic [2:0]               wake_vector    // Vector.
);
   // ********
   // Helpers
   // ********
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] stab_q;
   // Counts the oscillator settling time so the resume moment is bounded.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         stab_q <= 16'h0;
      else if (!clk_ctl.cpu_stopped)
         stab_q <= 16'h0;
      else if (clk_ctl.main_osc_enable)
         stab_q <= stab_q + 16'h1;
   // ********
   // Checks
   // ********
   chk_halt_entry: assert property (
      psel && penable && pwrite && paddr == SWK_ADDR_CTRL
      && pwdata[SWK_CTRL_HALT] && !clk_ctl.cpu_stopped
      |=> clk_ctl.cpu_stopped && !clk_ctl.main_osc_enable)
      else $error("halt write did not stop the oscillators");
   chk_osc_pair: assert property (
      clk_ctl.main_osc_enable == clk_ctl.sub_osc_enable)
      else $error("oscillator enables differ");
   chk_clock_held: assert property (
      clk_ctl.cpu_stopped |-> clk_ctl.internal_clock)
      else $error("internal clock not held high");
   chk_run_toggles: assert property (
      $past(presetn) && !clk_ctl.cpu_stopped && !$past(clk_ctl.cpu_stopped)
      |-> clk_ctl.internal_clock != $past(clk_ctl.internal_clock))
      else $error("internal clock idle in run");
   chk_wake_restart: assert property (
      $rose(clk_ctl.main_osc_enable) |-> clk_ctl.cpu_stopped)
      else $error("oscillators restarted outside wake");
   chk_stab_length: assert property (
      $fell(clk_ctl.cpu_stopped) |-> stab_q >= 16'h7FF0
      && stab_q <= 16'h8010)
      else $error("resume time outside chained count");
   chk_resume_pulse: assert property (
      wake_resume |-> $past(clk_ctl.cpu_stopped) ##1 !wake_resume)
      else $error("bad resume pulse");
   chk_vector_hold: assert property (
      $changed(wake_vector) |-> $rose(clk_ctl.main_osc_enable))
      else $error("vector changed without a wake");
   chk_halt_retain: assert property (
      clk_ctl.cpu_stopped && $past(clk_ctl.cpu_stopped)
      |-> $stable(key_pullup_en))
      else $error("pull-ups changed while halted");
   chk_bad_addr: assert property (
      psel && penable |-> pslverr == (paddr > SWK_ADDR_PULLUP
      || paddr[1:0] != 2'h0))
      else $error("wrong error response");
endmodule // swk_sequencer_checker
bind swk_sequencer swk_sequencer_checker u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pslverr, .key_pullup_en,
   .clk_ctl, .wake_resume, .wake_vector);
`default_nettype wire

// file: swk_wake_peer.sv
// Model of the external wake pins, key port and sub oscillator.
`timescale 1ns/10ps
`default_nettype none
module swk_wake_peer
   import swk_pkg::*;
(
   input  wire logic                    pclk,     // Clock.
   input  wire logic                    sub_run,  // Sub osc enabled.
   input  wire logic [SWK_KEY_BITS-1:0] key_pull, // Pull-up drive.
   output logic      [2:0]              pins,     // Wake pins.
   output logic                         sub_clk,  // Sub clock.
   output logic      [SWK_KEY_BITS-1:0] keys      // Key port.
);
   logic [7:0] press_q = 8'h00;
   logic [7:0] float_q = 8'h55;
   logic [1:0] div_q = 2'h0;
   initial
      pins = 3'h0;
   // pulled-up keys
   // A key without pull-up floats; a changing pattern stops the
   // simulator from settling it to a convenient level.
   assign keys = ~press_q & (key_pull | float_q);
   // The sub clock stands still while its oscillator is stopped.
   assign sub_clk = sub_run & div_q[1];
   always @(posedge pclk)
   begin
      float_q <= ~float_q;
      if (sub_run)
         div_q <= div_q + 2'h1;
   end
   task automatic toggle_pin(input int i);
      @(posedge pclk);
      pins[i] <= ~pins[i];
   endtask
   task automatic press_key(input int i, input logic down);
      @(posedge pclk);
      press_q[i] <= down;
   endtask
endmodule // swk_wake_peer
`default_nettype wire

// file: swk_sequencer_bench.sv
// Self-checking bench for the stop-mode wake sequencer.
`timescale 1ns/10ps
`default_nettype none
module swk_sequencer_bench;
   import swk_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   swk_wake_s   wake_src = 3'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, subclk, wake_resume, irq;
   logic [2:0]  pins, wake_vector;
   logic [7:0]  keys, pullups;
   swk_clk_s    clk_ctl;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;
   swk_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_irq_zero(pins[0]),
      .external_irq_one(pins[1]), .counter_pin_irq(pins[2]),
      .sub_oscillator_clock(subclk), .wake_src(wake_src),
      .key_pins(keys), .key_pullup_en(pullups), .clk_ctl(clk_ctl),
      .wake_resume(wake_resume), .wake_vector(wake_vector), .irq(irq));
   swk_wake_peer peer (.pclk(pclk), .sub_run(clk_ctl.sub_osc_enable),
      .key_pull(pullups), .pins(pins), .sub_clk(subclk), .keys(keys));
   initial
      forever #10 pclk = ~pclk;
   // Two wakes take some 66000 cycles; the ceiling leaves margin.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   // ********
   // Tasks
   // ********
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge pclk);
   endtask
   task automatic t_reset();
      rchk(SWK_ADDR_CTRL, 32'h0);
      rchk(SWK_ADDR_WAKE_EN, 32'h0);
      rchk(SWK_ADDR_IRQ_MASK, 32'h0);
      rchk(SWK_ADDR_IRQ_STAT, 32'h0);
      apb(1'b0, SWK_ADDR_STATUS, 32'h0);
      check(rd & 32'hFF, 32'h0C);
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      check({31'h0, err}, 32'h1);
      rchk(8'h20, 32'h0);
   endtask
   task automatic t_pullup();
      apb(1'b1, SWK_ADDR_PULLUP, 32'hA5);
      tick(2);
      check({24'h0, pullups}, 32'hA5);
   endtask
   task automatic t_timer_irq();
      int n;
      apb(1'b1, SWK_ADDR_T3, 32'h1);
      apb(1'b1, SWK_ADDR_CTRL, 32'h4);
      do
         apb(1'b0, SWK_ADDR_IRQ_STAT, 32'h0);
      while (rd[SWK_IRQ_T3] !== 1'b1);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, SWK_ADDR_IRQ_MASK, 32'h2);
      tick(2);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, SWK_ADDR_CTRL, 32'h0);
      apb(1'b1, SWK_ADDR_IRQ_STAT, 32'h2);
      tick(2);
      check({31'h0, irq}, 32'h0);
      // Sub clock source: four ticks of 64 cycles, far beyond main.
      apb(1'b1, SWK_ADDR_T3, 32'h3);
      apb(1'b1, SWK_ADDR_CTRL, 32'h6);
      n = 0;
      while (irq !== 1'b1 && n < 1000)
      begin
         tick(1);
         n++;
      end
      check(32'(n >= 180 && n <= 280), 32'h1);
      apb(1'b1, SWK_ADDR_CTRL, 32'h0);
   endtask
   task automatic t_halt_wake(input int src);
      int n;
      apb(1'b1, SWK_ADDR_PULLUP, 32'hFF);
      apb(1'b1, SWK_ADDR_IRQ_MASK, 32'h1);
      apb(1'b1, SWK_ADDR_T3, 32'hFF);
      apb(1'b1, SWK_ADDR_T4, 32'hFF);
      apb(1'b1, SWK_ADDR_CTRL, 32'h4);
      apb(1'b1, SWK_ADDR_WAKE_EN, 32'h1 << src);
      apb(1'b1, SWK_ADDR_IRQ_STAT, 32'hF);
      apb(1'b1, SWK_ADDR_CTRL, 32'h5);
      tick(1);
      check({28'h0, clk_ctl}, 32'h3);
      rchk(SWK_ADDR_T3, 32'hFF);
      rchk(SWK_ADDR_T4, 32'h07);
      apb(1'b1, SWK_ADDR_PULLUP, 32'h0);
      @(posedge pclk);
      wake_src <= 3'h7;
      @(posedge pclk);
      wake_src <= 3'h0;
      peer.toggle_pin(0);
      peer.toggle_pin(2);
      tick(8);
      check({28'h0, clk_ctl}, 32'h3);
      if (src == SWK_SRC_KEY)
         peer.press_key(0, 1'b1);
      else
         peer.toggle_pin(src);
      n = 0;
      while (wake_resume !== 1'b1)
      begin
         @(negedge pclk);
         n++;
      end
      check(32'(n >= 32752 && n <= 32784), 32'h1);
      check({29'h0, wake_vector}, 32'(src));
      tick(2);
      check({31'h0, irq}, 32'h1);
      apb(1'b0, SWK_ADDR_IRQ_STAT, 32'h0);
      check(rd & 32'h9, 32'h9);
      rchk(SWK_ADDR_PULLUP, 32'hFF);
      peer.press_key(0, 1'b0);
      apb(1'b1, SWK_ADDR_IRQ_STAT, 32'hF);
      tick(2);
      check({31'h0, irq}, 32'h0);
   endtask
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pullup();
      t_timer_irq();
      t_halt_wake(SWK_SRC_IRQ1);
      t_halt_wake(SWK_SRC_KEY);
      report_and_stop();
   end
endmodule // swk_sequencer_bench
`default_nettype wire
